// ---- logic/diag_record_pkg.sv ----
`default_nettype none
package diag_record_pkg;

   // record shape
   localparam int NUM_INPUTS       = 16;
   localparam int NUM_COUNTERS     = 4;
   localparam int SRC_PER_COUNTER  = 4;
   localparam int NUM_GROUPS       = 8;
   localparam int NUM_SOURCES      = NUM_INPUTS
                                     + NUM_COUNTERS * SRC_PER_COUNTER;
   localparam int FLAGS_PER_BYTE   = 4;

   // word indices; byte address is four times the index
   localparam logic [5:0] IDX_CHAN_TYPE      = 6'h04;
   localparam logic [5:0] IDX_DIAG_BITS      = 6'h05;
   localparam logic [5:0] IDX_CHAN_COUNT     = 6'h06;
   localparam logic [5:0] IDX_GROUP_ERR      = 6'h07;
   localparam logic [5:0] IDX_LOST_IN_0_3    = 6'h08;
   localparam logic [5:0] IDX_LOST_IN_4_7    = 6'h09;
   localparam logic [5:0] IDX_LOST_IN_8_11   = 6'h0a;
   localparam logic [5:0] IDX_LOST_IN_12_15  = 6'h0b;
   localparam logic [5:0] IDX_LOST_CNT_ZERO  = 6'h0c;
   localparam logic [5:0] IDX_LOST_CNT_ONE   = 6'h0d;
   localparam logic [5:0] IDX_LOST_CNT_TWO   = 6'h0e;
   localparam logic [5:0] IDX_LOST_CNT_THREE = 6'h0f;
   localparam logic [5:0] IDX_CTRL           = 6'h10;
   localparam logic [5:0] IDX_BUSY           = 6'h11;

   // descriptor contents
   localparam logic [7:0] CHAN_TYPE_DIG_IN   = 8'h70;
   localparam logic [7:0] DIAG_BITS_PER_CHAN = 8'h08;
   localparam logic [7:0] CHANNEL_COUNT      = 8'h08;

   // control register fields
   localparam int CTRL_CAPTURE_BIT = 0;
   localparam int CTRL_CLEAR_BIT   = 1;
   localparam int CTRL_TAKEN_BIT   = 2;

   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // reset values
   localparam logic [31:0] RST_WORD  = 32'h0000_0000;
   localparam logic [7:0]  RST_GROUP = 8'h00;

endpackage
`default_nettype wire

// ---- logic/level_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module level_sync
   import diag_record_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input  wire logic             sys_clk_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] async_i,
   output var  logic [WIDTH-1:0] level_o
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // three stages; a bit moves only when the last two agree
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         stage1  <= '0;
         stage2  <= '0;
         stage3  <= '0;
         level_o <= '0;
      end
      else
      begin
         stage1 <= async_i;
         stage2 <= stage1;
         stage3 <= stage2;
         for (int i = 0; i < WIDTH; i++)
         begin
            if (stage2[i] == stage3[i])
               level_o[i] <= stage3[i];
         end
      end
   end

endmodule
`default_nettype wire

// ---- logic/lost_irq_tracker.sv ----
`timescale 1ns/10ps
`default_nettype none
module lost_irq_tracker
   import diag_record_pkg::*;
#(
   parameter int N = 32
)
(
   input  wire logic         sys_clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [N-1:0] event_i,
   input  wire logic [N-1:0] done_i,
   input  wire logic [N-1:0] clear_i,
   output var  logic [N-1:0] busy_o,
   output var  logic [N-1:0] lost_o
);

   logic [N-1:0] busy_end;

   // a source whose handling ends this cycle may take a new event
   assign busy_end = busy_o & done_i;

   // handling in progress per source
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         busy_o <= '0;
      else
         busy_o <= (busy_o & ~done_i) | event_i;
   end

   // event on a busy source is lost; set wins over clear
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         lost_o <= '0;
      else
         lost_o <= (lost_o & ~clear_i)
                   | (event_i & busy_o & ~busy_end);
   end

endmodule
`default_nettype wire

// ---- logic/io_counter_diag_record.sv ----
`timescale 1ns/10ps
`default_nettype none
module io_counter_diag_record
   import diag_record_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input  wire logic              sys_clk_i,
   input  wire logic              nrst_i,
   // channel group error levels from the field side
   input  wire logic [NUM_GROUPS-1:0]  group_err_i,
   // process interrupt requests and end-of-handling, same clock
   input  wire logic [NUM_SOURCES-1:0] irq_event_i,
   input  wire logic [NUM_SOURCES-1:0] irq_done_i,
   // axi4-lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output var  logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output var  logic              s_axi_wready,
   output var  logic [1:0]        s_axi_bresp,
   output var  logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output var  logic              s_axi_arready,
   output var  logic [31:0]       s_axi_rdata,
   output var  logic [1:0]        s_axi_rresp,
   output var  logic              s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   ////////////////////////////////////////////////////////////////////////
   // reset release

   logic rst_meta;
   logic rst_n;

   // async assert, two-stage release
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // declarations

   logic [NUM_GROUPS-1:0]  group_err;
   logic [NUM_SOURCES-1:0] busy;
   logic [NUM_SOURCES-1:0] lost;
   logic [NUM_SOURCES-1:0] clear_vec;
   logic [NUM_GROUPS-1:0]  snap_group;
   logic [NUM_SOURCES-1:0] snap_lost;
   logic                   snap_taken;
   logic                   capture;
   logic                   clear_lost;
   logic [ADDR_W-1:0]      aw_addr;
   logic                   aw_got;
   logic [31:0]            w_data;
   logic [3:0]             w_strb;
   logic                   w_got;
   logic                   do_write;
   logic [5:0]             aw_idx;
   logic [5:0]             ar_idx;
   logic                   ctrl_hit;
   logic [31:0]            read_word;
   logic                   read_ok;

   ////////////////////////////////////////////////////////////////////////
   // field-side levels and lost-interrupt tracking

   level_sync #(
      .WIDTH (NUM_GROUPS)
   ) u_group_sync (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n),
      .async_i   (group_err_i),
      .level_o   (group_err)
   );

   // software clear reaches every source at once
   assign clear_vec = {NUM_SOURCES{clear_lost}};

   lost_irq_tracker #(
      .N (NUM_SOURCES)
   ) u_tracker (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n),
      .event_i   (irq_event_i),
      .done_i    (irq_done_i),
      .clear_i   (clear_vec),
      .busy_o    (busy),
      .lost_o    (lost)
   );

   ////////////////////////////////////////////////////////////////////////
   // snapshot of the record

   // software reads the record from the frozen copy, so bytes never tear; the busy word is read live
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         snap_group <= RST_GROUP;
         snap_lost  <= '0;
         snap_taken <= 1'b0;
      end
      else if (capture)
      begin
         snap_group <= group_err;
         snap_lost  <= lost;
         snap_taken <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // record byte layout

   // four flags spread over even bits, odd bits fixed zero
   function automatic logic [7:0] spread(input logic [3:0] f);
      spread = {1'b0, f[3], 1'b0, f[2], 1'b0, f[1], 1'b0, f[0]};
   endfunction

   // flag group m of the snapshot in byte form
   function automatic logic [7:0] lost_byte(input int m,
                                            input logic [31:0] v);
      lost_byte = spread(v[m*FLAGS_PER_BYTE +: FLAGS_PER_BYTE]);
   endfunction

   assign ar_idx = s_axi_araddr[7:2];

   // read mux; unmapped words answer slverr with zero data
   always_comb
   begin
      read_word = RST_WORD;
      read_ok   = 1'b1;
      case (ar_idx)
         IDX_CHAN_TYPE:
            read_word[7:0] = CHAN_TYPE_DIG_IN;
         IDX_DIAG_BITS:
            read_word[7:0] = DIAG_BITS_PER_CHAN;
         IDX_CHAN_COUNT:
            read_word[7:0] = CHANNEL_COUNT;
         IDX_GROUP_ERR:
            read_word[7:0] = snap_group;
         IDX_LOST_IN_0_3:
            read_word[7:0] = lost_byte(0, snap_lost);
         IDX_LOST_IN_4_7:
            read_word[7:0] = lost_byte(1, snap_lost);
         IDX_LOST_IN_8_11:
            read_word[7:0] = lost_byte(2, snap_lost);
         IDX_LOST_IN_12_15:
            read_word[7:0] = lost_byte(3, snap_lost);
         IDX_LOST_CNT_ZERO:
            read_word[7:0] = lost_byte(4, snap_lost);
         IDX_LOST_CNT_ONE:
            read_word[7:0] = lost_byte(5, snap_lost);
         IDX_LOST_CNT_TWO:
            read_word[7:0] = lost_byte(6, snap_lost);
         IDX_LOST_CNT_THREE:
            read_word[7:0] = lost_byte(7, snap_lost);
         IDX_CTRL:
            read_word[CTRL_TAKEN_BIT] = snap_taken;
         IDX_BUSY:
            read_word = busy;
         default:
            read_ok = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite write path

   assign aw_idx   = aw_addr[7:2];
   assign ctrl_hit = (aw_idx == IDX_CTRL);
   assign do_write = aw_got & w_got & ~s_axi_bvalid;

   // address channel; reopens only after the response is taken
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_awready <= 1'b0;
         aw_got        <= 1'b0;
         aw_addr       <= '0;
      end
      else if (s_axi_awready && s_axi_awvalid)
      begin
         s_axi_awready <= 1'b0;
         aw_got        <= 1'b1;
         aw_addr       <= s_axi_awaddr;
      end
      else if (do_write)
         aw_got <= 1'b0;
      else if (!aw_got && !s_axi_bvalid)
         s_axi_awready <= 1'b1;
   end

   // data channel, independent of the address channel
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_wready <= 1'b0;
         w_got        <= 1'b0;
         w_data       <= RST_WORD;
         w_strb       <= 4'h0;
      end
      else if (s_axi_wready && s_axi_wvalid)
      begin
         s_axi_wready <= 1'b0;
         w_got        <= 1'b1;
         w_data       <= s_axi_wdata;
         w_strb       <= s_axi_wstrb;
      end
      else if (do_write)
         w_got <= 1'b0;
      else if (!w_got && !s_axi_bvalid)
         s_axi_wready <= 1'b1;
   end

   // response; only the control word is writable
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= ctrl_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // control strobes are one-cycle pulses, the word reads back only the taken bit
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         capture    <= 1'b0;
         clear_lost <= 1'b0;
      end
      else
      begin
         capture    <= do_write & ctrl_hit & w_strb[0]
                       & w_data[CTRL_CAPTURE_BIT];
         clear_lost <= do_write & ctrl_hit & w_strb[0]
                       & w_data[CTRL_CLEAR_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite read path

   // one read in flight; data sampled at the address handshake
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= RST_WORD;
         s_axi_rresp   <= RESP_OKAY;
      end
      else if (s_axi_arready && s_axi_arvalid)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= read_word;
         s_axi_rresp   <= read_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
      else if (!s_axi_rvalid)
         s_axi_arready <= 1'b1;
   end

endmodule
`default_nettype wire

// ---- test/io_counter_diag_record_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module io_counter_diag_record_monitor
   import diag_record_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic              sys_clk_i,
   input wire logic              nrst_i,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp
);
   logic [ADDR_W-1:0] rd_addr;

   ////////////////////////////////////////////////////////////////////////
   // keep the read address, the bus drops it once taken
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rd_addr <= '0;
      else if (s_axi_arvalid && s_axi_arready)
         rd_addr <= s_axi_araddr;
   end

   ////////////////////////////////////////////////////////////////////////
   // one clock domain, so one default clock and reset
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   a_chan_type : assert property (
      s_axi_rvalid && rd_addr == 'h10 |-> s_axi_rdata == 32'h0000_0070)
      else $error("channel type word wrong");
   a_diag_bits : assert property (
      s_axi_rvalid && rd_addr == 'h14 |-> s_axi_rdata == 32'h0000_0008)
      else $error("diag bit count word wrong");
   a_chan_count : assert property (
      s_axi_rvalid && rd_addr == 'h18 |-> s_axi_rdata == 32'h0000_0008)
      else $error("channel count word wrong");
   a_group_width : assert property (
      s_axi_rvalid && rd_addr == 'h1c
      |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rresp == RESP_OKAY)
      else $error("group word has stray bits");
   a_lost_odd_zero : assert property (
      s_axi_rvalid && rd_addr inside {['h20:'h3c]}
      |-> (s_axi_rdata & 32'hffff_ffaa) == 32'h0)
      else $error("lost flag word has odd or high bits set");
   a_read_hold : assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data moved before it was taken");
   a_read_answer : assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_answer : assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_resp_hold : assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped early");

   // main scenarios seen
   c_group_read : cover property (
      s_axi_rvalid && rd_addr == 'h1c && s_axi_rdata != 32'h0);
   c_lost_read : cover property (
      s_axi_rvalid && rd_addr == 'h3c && s_axi_rdata != 32'h0);
   c_refused : cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   c_read_wait : cover property (s_axi_rvalid && !s_axi_rready);
endmodule

bind io_counter_diag_record io_counter_diag_record_monitor
   #(.ADDR_W(ADDR_W)) io_counter_diag_record_monitor_i (
   .sys_clk_i, .nrst_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
`default_nettype wire

// ---- test/io_counter_diag_record_test.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module io_counter_diag_record_test
   import diag_record_pkg::*;
   ;
   logic        sys_clk, nrst, awvalid, wvalid, arvalid, bready, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr, araddr, group_err;
   logic [31:0] wdata, rdata, irq_event, irq_done;
   logic [1:0]  bresp, rresp;
   logic [3:0]  wstrb;
   logic [2:0]  awprot, arprot;
   int          err_total, n_tests;
   int          ready_lag; // edges before bready/rready rise, tests holding

   ////////////////////////////////////////////////////////////////////////
   // 200 mhz clock
   always #2.5 sys_clk = ~sys_clk;

   io_counter_diag_record #(.ADDR_W(8)) io_counter_diag_record_i (
      .sys_clk_i(sys_clk), .nrst_i(nrst), .group_err_i(group_err),
      .irq_event_i(irq_event), .irq_done_i(irq_done),
      .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(arprot),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));

   ////////////////////////////////////////////////////////////////////////
   // bus master; address and data are released one by one as taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] er);
      int   n;
      logic aw_ok, w_ok;
      n = 0;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_ok && w_ok) && n < 100)
      begin
         @(posedge sys_clk);
         n++;
         if (!aw_ok && awready)
         begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready)
         begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      repeat (ready_lag) @(posedge sys_clk);
      bready <= 1'b1;
      do @(posedge sys_clk); while (!bvalid && ++n < 200);
      bready <= 1'b0;
      `CHK({bvalid, bresp}, {1'b1, er})
   endtask

   // read one word and compare data and answer code
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                         input logic [1:0] er);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge sys_clk); while (!arready && ++n < 100);
      arvalid <= 1'b0;
      repeat (ready_lag) @(posedge sys_clk);
      rready <= 1'b1;
      do @(posedge sys_clk); while (!rvalid && ++n < 200);
      rready <= 1'b0;
      `CHK({rvalid, rresp, rdata}, {1'b1, er, ed})
   endtask

   // expected lost word: four sources per byte on even bits
   function automatic logic [31:0] lost_word(input logic [31:0] p,
                                             input int b);
      lost_word = 32'h0;
      for (int j = 0; j < 4; j++)
         lost_word[2*j] = p[4*b+j];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // descriptors, unmapped place, read-only record
   task automatic t_desc();
      axi_rd(8'h10, 32'h0000_0070, RESP_OKAY);
      axi_rd(8'h14, 32'h0000_0008, RESP_OKAY);
      axi_rd(8'h18, 32'h0000_0008, RESP_OKAY);
      axi_rd(8'h00, 32'h0000_0000, RESP_SLVERR);
      axi_wr(8'h1c, 32'h0000_00ff, RESP_SLVERR);
      axi_rd(8'h1c, 32'h0000_0000, RESP_OKAY);
      $display("test descriptors done");
   endtask

   // group flags land on their bits; snapshot ignores later changes
   task automatic t_group();
      group_err <= 8'ha5;
      repeat (8) @(posedge sys_clk);
      axi_wr(8'h40, 32'h1, RESP_OKAY);
      axi_rd(8'h1c, 32'h0000_00a5, RESP_OKAY);
      group_err <= 8'h5a;
      repeat (8) @(posedge sys_clk);
      wstrb <= 4'he;
      axi_wr(8'h40, 32'h1, RESP_OKAY);
      wstrb <= 4'hf;
      axi_rd(8'h1c, 32'h0000_00a5, RESP_OKAY);
      axi_wr(8'h40, 32'h1, RESP_OKAY);
      axi_rd(8'h1c, 32'h0000_005a, RESP_OKAY);
      axi_rd(8'h40, 32'h0000_0004, RESP_OKAY);
      $display("test group flags done");
   endtask

   // second event while busy is lost; event with done is not
   task automatic t_lost(input logic [31:0] p);
      irq_event <= 32'hffff_ffff;
      @(posedge sys_clk);
      irq_event <= p;
      @(posedge sys_clk);
      irq_event <= ~p;
      irq_done <= ~p;
      @(posedge sys_clk);
      irq_event <= 32'h0;
      irq_done <= 32'h0;
      axi_rd(8'h44, 32'hffff_ffff, RESP_OKAY);
      irq_done <= 32'hffff_ffff;
      @(posedge sys_clk);
      irq_done <= 32'h0;
      @(posedge sys_clk);
      axi_rd(8'h44, 32'h0, RESP_OKAY);
      axi_wr(8'h40, 32'h1, RESP_OKAY);
      for (int b = 0; b < 8; b++)
         axi_rd(8'h20 + 8'(4*b), lost_word(p, b), RESP_OKAY);
      axi_wr(8'h40, 32'h2, RESP_OKAY);
      axi_wr(8'h40, 32'h1, RESP_OKAY);
      for (int b = 0; b < 8; b++)
         axi_rd(8'h20 + 8'(4*b), 32'h0, RESP_OKAY);
      $display("test lost flags done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // verdict, reached from the main sequence or the watchdog
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // main sequence
   initial
   begin
      {sys_clk, nrst, awvalid, wvalid, arvalid, bready, rready} = '0;
      {awaddr, araddr, group_err, wdata, irq_event, irq_done} = '0;
      {awprot, arprot} = '0;
      wstrb = 4'hf;
      err_total = 0;
      n_tests = 0;
      ready_lag = 0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      t_desc();
      t_group();
      t_lost(32'h8c3a_51e6);
      // late bready/rready, so answers must stand
      ready_lag = 2;
      t_lost(32'h73c5_ae19);
      end_sim();
   end

   // watchdog, far beyond the few hundred cycles the run needs
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      end_sim();
   end
endmodule
`default_nettype wire
